/* logic/ltx_decode.sv */
// opcode decoder for the logic, exclusive-or, extract and subroutine branch unit
`timescale 1ns/1ps
`default_nettype none
`include "ltx_defines.svh"
module ltx_decode
	import ltx_pkg::*;
(
	input wire logic [15:0] code_in,
	output ltx_dec_t dec_out
);

	logic [15:0] c;
	logic is_branch;
	assign c = code_in;

	// classify the word and pull out its fields
	always_comb begin
		dec_out.rn = c[`LTX_RN_HI:`LTX_RN_LO];
		dec_out.rm = c[`LTX_RM_HI:`LTX_RM_LO];
		dec_out.imm = c[7:0];
		dec_out.disp = c[11:0];
		dec_out.is_branch = is_branch; // one process owns the whole struct
		dec_out.op = LTX_OP_OTHER;
		if ((c & `LTX_MASK_RR) == `LTX_PAT_TST_REG) begin
			dec_out.op = LTX_OP_TST_REG;
		end else if ((c & `LTX_MASK_IMM) == `LTX_PAT_TST_IMM) begin
			dec_out.op = LTX_OP_TST_IMM;
		end else if ((c & `LTX_MASK_IMM) == `LTX_PAT_TST_MEM) begin
			dec_out.op = LTX_OP_TST_MEM;
		end else if ((c & `LTX_MASK_RR) == `LTX_PAT_XOR_REG) begin
			dec_out.op = LTX_OP_XOR_REG;
		end else if ((c & `LTX_MASK_IMM) == `LTX_PAT_XOR_IMM) begin
			dec_out.op = LTX_OP_XOR_IMM;
		end else if ((c & `LTX_MASK_IMM) == `LTX_PAT_XOR_MEM) begin
			dec_out.op = LTX_OP_XOR_MEM;
		end else if ((c & `LTX_MASK_RR) == `LTX_PAT_EXTRACT) begin
			dec_out.op = LTX_OP_EXTRACT;
		end else if ((c & `LTX_MASK_TOP) == `LTX_PAT_BSR) begin
			dec_out.op = LTX_OP_BSR;
		end else if ((c & `LTX_MASK_RN) == `LTX_PAT_REGISTER_RELATIVE_SUBROUTINE_BRANCH) begin
			dec_out.op = LTX_OP_REGISTER_RELATIVE_SUBROUTINE_BRANCH;
		end
	end

	// every branch form, so a delay slot can refuse it
	assign is_branch = ((c & `LTX_MASK_TOP) == `LTX_PAT_BSR)
		|| ((c & `LTX_MASK_TOP) == `LTX_PAT_BRA)
		|| ((c & `LTX_MASK_RN) == `LTX_PAT_REGISTER_RELATIVE_SUBROUTINE_BRANCH)
		|| ((c & `LTX_MASK_RN) == `LTX_PAT_BRAF)
		|| ((c & `LTX_MASK_RN) == `LTX_PAT_JSR)
		|| ((c & `LTX_MASK_RN) == `LTX_PAT_JMP)
		|| (c == `LTX_PAT_RTS)
		|| (c == `LTX_PAT_RTE)
		|| ((c & `LTX_MASK_IMM) == `LTX_PAT_TRAP)
		|| ((c & `LTX_MASK_IMM) == `LTX_PAT_BT)
		|| ((c & `LTX_MASK_IMM) == `LTX_PAT_BF)
		|| ((c & `LTX_MASK_IMM) == `LTX_PAT_BTS)
		|| ((c & `LTX_MASK_IMM) == `LTX_PAT_BFS);

endmodule
`default_nettype wire

/* logic/ltx_defines.svh */
// shared constants for the logic, exclusive-or, extract and subroutine branch unit
`ifndef LTX_DEFINES_SVH
`define LTX_DEFINES_SVH

// opcode match patterns and masks
`define LTX_MASK_RR 16'hF00F
`define LTX_MASK_IMM 16'hFF00
`define LTX_MASK_TOP 16'hF000
`define LTX_MASK_RN 16'hF0FF
`define LTX_PAT_TST_REG 16'h2008
`define LTX_PAT_XOR_REG 16'h200A
`define LTX_PAT_EXTRACT 16'h200D
`define LTX_PAT_TST_IMM 16'hC800
`define LTX_PAT_XOR_IMM 16'hCA00
`define LTX_PAT_TST_MEM 16'hCC00
`define LTX_PAT_XOR_MEM 16'hCE00
`define LTX_PAT_BSR 16'hB000
`define LTX_PAT_REGISTER_RELATIVE_SUBROUTINE_BRANCH 16'h0003
// other branches, recognised only so a delay slot can refuse them
`define LTX_PAT_BRA 16'hA000
`define LTX_PAT_BRAF 16'h0023
`define LTX_PAT_JSR 16'h400B
`define LTX_PAT_JMP 16'h402B
`define LTX_PAT_RTS 16'h000B
`define LTX_PAT_RTE 16'h002B
`define LTX_PAT_TRAP 16'hC300
`define LTX_PAT_BT 16'h8900
`define LTX_PAT_BF 16'h8B00
`define LTX_PAT_BTS 16'h8D00
`define LTX_PAT_BFS 16'h8F00

// field positions
`define LTX_RN_HI 11
`define LTX_RN_LO 8
`define LTX_RM_HI 7
`define LTX_RM_LO 4

// address arithmetic
`define LTX_PC_STEP 32'h0000_0004

// exception codes
`define LTX_EXC_W 3
`define LTX_EXC_NONE 3'h0
`define LTX_EXC_MULTI_HIT 3'h1
`define LTX_EXC_MISS 3'h2
`define LTX_EXC_PROTECT 3'h3
`define LTX_EXC_FIRST_WRITE 3'h4
`define LTX_EXC_ADDR_ERROR 3'h5
`define LTX_EXC_SLOT_ILLEGAL 3'h6

// reset values
`define LTX_RST_WORD 32'h0000_0000
`define LTX_RST_FLAG 1'h0

`endif

/* logic/ltx_exec.sv */
// execution unit for test, exclusive-or, extract and delayed subroutine branches
`timescale 1ns/1ps
`default_nettype none
`include "ltx_defines.svh"
module ltx_exec
	import ltx_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic instr_valid_in,
	input wire ltx_instr_t instr_in,
	output logic instr_ready_out,
	output logic done_out,
	output logic redirect_valid_out,
	output logic [31:0] redirect_pc_out,
	output logic exc_valid_out,
	output logic [`LTX_EXC_W-1:0] exc_code_out,
	input wire logic irq_req_in,
	output logic irq_accept_out,
	output logic mem_valid_out,
	output ltx_mem_req_t mem_req_out,
	input wire logic mem_ack_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic [`LTX_EXC_W-1:0] mem_err_in,
	input wire logic reg_wr_en_in,
	input wire logic [3:0] reg_wr_sel_in,
	input wire logic [31:0] reg_wr_data_in,
	input wire logic base_load_in,
	input wire logic [31:0] base_value_in,
	input wire logic [3:0] reg_sel_in,
	output logic [31:0] reg_value_out,
	output logic t_flag_out,
	output logic [31:0] return_register_out,
	output logic [31:0] global_base_out
);

	// general registers, left unreset like any register file
	logic [31:0] gpr [0:15];

	ltx_dec_t dec;
	ltx_state_t state;
	ltx_state_t next_state;
	logic t_flag;
	logic next_t_flag;
	logic [31:0] return_register;
	logic [31:0] next_return_register;
	logic [31:0] global_base;
	logic [31:0] next_global_base;
	logic slot_pending;
	logic next_slot_pending;
	logic [31:0] branch_target;
	logic [31:0] next_branch_target;
	ltx_op_t mem_op;
	ltx_op_t next_mem_op;
	logic [7:0] mem_imm;
	logic [7:0] next_mem_imm;
	logic mem_valid;
	logic next_mem_valid;
	ltx_mem_req_t mem_req;
	ltx_mem_req_t next_mem_req;
	logic done;
	logic next_done;
	logic redirect_valid;
	logic next_redirect_valid;
	logic [31:0] redirect_pc;
	logic [31:0] next_redirect_pc;
	logic exc_valid;
	logic next_exc_valid;
	logic [`LTX_EXC_W-1:0] exc_code;
	logic [`LTX_EXC_W-1:0] next_exc_code;
	logic [31:0] reg_value;
	logic [31:0] next_reg_value;
	logic rf_we;
	logic [3:0] rf_waddr;
	logic [31:0] rf_wdata;
	logic accept;
	logic [31:0] rn_val;
	logic [31:0] rm_val;
	logic [31:0] r0_val;
	logic [31:0] link_addr;
	logic [31:0] disp_ext;

	ltx_decode u_decode (
		.code_in(instr_in.code),
		.dec_out(dec)
	);

	// operand reads and shared branch arithmetic
	assign rn_val = gpr[dec.rn];
	assign rm_val = gpr[dec.rm];
	assign r0_val = gpr[4'h0];
	assign link_addr = instr_in.pc + `LTX_PC_STEP;
	assign disp_ext = {{19{dec.disp[11]}}, dec.disp, 1'b0};

	// one request at a time; the unit is busy during a byte access
	assign instr_ready_out = (state == LTX_ST_IDLE);
	assign accept = instr_valid_in && instr_ready_out;
	// interrupts wait while an access runs or a slot is still owed
	assign irq_accept_out = irq_req_in && (state == LTX_ST_IDLE) && !slot_pending;

	// next state of the whole unit
	always_comb begin
		next_state = state;
		next_t_flag = t_flag;
		next_return_register = return_register;
		next_global_base = base_load_in ? base_value_in : global_base;
		next_slot_pending = slot_pending;
		next_branch_target = branch_target;
		next_mem_op = mem_op;
		next_mem_imm = mem_imm;
		next_mem_valid = mem_valid;
		next_mem_req = mem_req;
		next_done = 1'b0;
		next_redirect_valid = 1'b0;
		next_redirect_pc = redirect_pc;
		next_exc_valid = 1'b0;
		next_exc_code = exc_code;
		next_reg_value = gpr[reg_sel_in];
		rf_we = reg_wr_en_in;
		rf_waddr = reg_wr_sel_in;
		rf_wdata = reg_wr_data_in;
		unique case (state)
			LTX_ST_IDLE: begin
				if (accept && slot_pending && dec.is_branch) begin
					// the slotted branch never runs and the target is dropped
					next_exc_valid = 1'b1;
					next_exc_code = `LTX_EXC_SLOT_ILLEGAL;
					next_slot_pending = 1'b0;
				end else if (accept) begin
					// single-cycle forms finish here; memory forms override below
					next_done = 1'b1;
					if (slot_pending) begin
						next_redirect_valid = 1'b1;
						next_redirect_pc = branch_target;
						next_slot_pending = 1'b0;
					end
					unique case (dec.op)
						LTX_OP_TST_REG: begin
							next_t_flag = ((rn_val & rm_val) == 32'h0000_0000);
						end
						LTX_OP_TST_IMM: begin
							next_t_flag = ((r0_val & {24'h00_0000, dec.imm}) == 32'h0000_0000);
						end
						LTX_OP_XOR_REG: begin
							rf_we = 1'b1;
							rf_waddr = dec.rn;
							rf_wdata = rn_val ^ rm_val;
						end
						LTX_OP_XOR_IMM: begin
							rf_we = 1'b1;
							rf_waddr = 4'h0;
							rf_wdata = r0_val ^ {24'h00_0000, dec.imm};
						end
						LTX_OP_EXTRACT: begin
							rf_we = 1'b1;
							rf_waddr = dec.rn;
							rf_wdata = {rm_val[15:0], rn_val[31:16]};
						end
						LTX_OP_BSR: begin
							next_return_register = link_addr;
							next_branch_target = link_addr + disp_ext;
							next_slot_pending = 1'b1;
						end
						LTX_OP_REGISTER_RELATIVE_SUBROUTINE_BRANCH: begin
							next_return_register = link_addr;
							next_branch_target = link_addr + rn_val;
							next_slot_pending = 1'b1;
						end
						LTX_OP_TST_MEM, LTX_OP_XOR_MEM: begin
							// slot completion is deferred until the access ends
							next_done = 1'b0;
							next_redirect_valid = 1'b0;
							next_slot_pending = slot_pending;
							next_state = LTX_ST_READ;
							next_mem_op = dec.op;
							next_mem_imm = dec.imm;
							next_mem_valid = 1'b1;
							next_mem_req.write = 1'b0;
							next_mem_req.check_both = 1'b1;
							next_mem_req.addr = global_base + r0_val;
							next_mem_req.wdata = 8'h00;
						end
						default: begin
							// anything else retires with no effect here
						end
					endcase
				end
			end
			LTX_ST_READ: begin
				if (mem_ack_in && (mem_err_in != `LTX_EXC_NONE)) begin
					// a faulted access also cancels any owed branch
					next_exc_valid = 1'b1;
					next_exc_code = mem_err_in;
					next_mem_valid = 1'b0;
					next_slot_pending = 1'b0;
					next_state = LTX_ST_IDLE;
				end else if (mem_ack_in && (mem_op == LTX_OP_TST_MEM)) begin
					next_t_flag = ((mem_rdata_in & mem_imm) == 8'h00);
					next_mem_valid = 1'b0;
					next_done = 1'b1;
					next_redirect_valid = slot_pending;
					next_redirect_pc = slot_pending ? branch_target : redirect_pc;
					next_slot_pending = 1'b0;
					next_state = LTX_ST_IDLE;
				end else if (mem_ack_in) begin
					next_mem_req.write = 1'b1;
					next_mem_req.wdata = mem_rdata_in ^ mem_imm;
					next_state = LTX_ST_WRITE;
				end
			end
			LTX_ST_WRITE: begin
				if (mem_ack_in && (mem_err_in != `LTX_EXC_NONE)) begin
					next_exc_valid = 1'b1;
					next_exc_code = mem_err_in;
					next_mem_valid = 1'b0;
					next_slot_pending = 1'b0;
					next_state = LTX_ST_IDLE;
				end else if (mem_ack_in) begin
					next_mem_valid = 1'b0;
					next_done = 1'b1;
					next_redirect_valid = slot_pending;
					next_redirect_pc = slot_pending ? branch_target : redirect_pc;
					next_slot_pending = 1'b0;
					next_state = LTX_ST_IDLE;
				end
			end
			default: begin
				// illegal one-hot code falls back to idle
				next_state = LTX_ST_IDLE;
				next_mem_valid = 1'b0;
			end
		endcase
	end

	// register everything; test flag only moves in the test paths above
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state <= LTX_ST_IDLE;
			t_flag <= `LTX_RST_FLAG;
			return_register <= `LTX_RST_WORD;
			global_base <= `LTX_RST_WORD;
			slot_pending <= 1'b0;
			branch_target <= `LTX_RST_WORD;
			mem_op <= LTX_OP_OTHER;
			mem_imm <= 8'h00;
			mem_valid <= 1'b0;
			mem_req <= '0;
			done <= 1'b0;
			redirect_valid <= 1'b0;
			redirect_pc <= `LTX_RST_WORD;
			exc_valid <= 1'b0;
			exc_code <= `LTX_EXC_NONE;
			reg_value <= `LTX_RST_WORD;
		end else begin
			state <= next_state;
			t_flag <= next_t_flag;
			return_register <= next_return_register;
			global_base <= next_global_base;
			slot_pending <= next_slot_pending;
			branch_target <= next_branch_target;
			mem_op <= next_mem_op;
			mem_imm <= next_mem_imm;
			mem_valid <= next_mem_valid;
			mem_req <= next_mem_req;
			done <= next_done;
			redirect_valid <= next_redirect_valid;
			redirect_pc <= next_redirect_pc;
			exc_valid <= next_exc_valid;
			exc_code <= next_exc_code;
			reg_value <= next_reg_value;
		end
	end

	// register file write; execution has priority over the setup port
	always_ff @(posedge clk_in) begin
		if (rf_we) begin
			gpr[rf_waddr] <= rf_wdata;
		end
	end

	// outputs straight from flip-flops
	assign done_out = done;
	assign redirect_valid_out = redirect_valid;
	assign redirect_pc_out = redirect_pc;
	assign exc_valid_out = exc_valid;
	assign exc_code_out = exc_code;
	assign mem_valid_out = mem_valid;
	assign mem_req_out = mem_req;
	assign reg_value_out = reg_value;
	assign t_flag_out = t_flag;
	assign return_register_out = return_register;
	assign global_base_out = global_base;

endmodule
`default_nettype wire

/* logic/ltx_pkg.sv */
// types for the logic, exclusive-or, extract and subroutine branch unit
`include "ltx_defines.svh"
package ltx_pkg;

	typedef enum logic [3:0] {
		LTX_OP_OTHER,
		LTX_OP_TST_REG,
		LTX_OP_TST_IMM,
		LTX_OP_TST_MEM,
		LTX_OP_XOR_REG,
		LTX_OP_XOR_IMM,
		LTX_OP_XOR_MEM,
		LTX_OP_EXTRACT,
		LTX_OP_BSR,
		LTX_OP_REGISTER_RELATIVE_SUBROUTINE_BRANCH
	} ltx_op_t;

	typedef enum logic [2:0] {
		LTX_ST_IDLE = 3'b001,
		LTX_ST_READ = 3'b010,
		LTX_ST_WRITE = 3'b100
	} ltx_state_t;

	// instruction word together with its own address
	typedef struct packed {
		logic [31:0] pc;
		logic [15:0] code;
	} ltx_instr_t;

	typedef struct packed {
		ltx_op_t op;
		logic [3:0] rn;
		logic [3:0] rm;
		logic [7:0] imm;
		logic [11:0] disp;
		logic is_branch;
	} ltx_dec_t;

	// byte access toward data memory
	typedef struct packed {
		logic write;
		logic check_both;
		logic [31:0] addr;
		logic [7:0] wdata;
	} ltx_mem_req_t;

endpackage

/* testbench/logic_test_xor_extract_subroutine_branch_bench.sv */
// self-checking bench for the test, exclusive-or, extract and branch unit
`timescale 1ns/1ps
`default_nettype none
module logic_test_xor_extract_subroutine_branch_bench
	import ltx_pkg::*;
;
	logic clk_in = 1'h0, reset_in = 1'h1, instr_valid_in = 1'h0, irq_req_in = 1'h0;
	logic reg_wr_en_in = 1'h0, base_load_in = 1'h0, mem_ack_in, instr_ready_out, done_out;
	logic redirect_valid_out, exc_valid_out, irq_accept_out, mem_valid_out, t_flag_out;
	logic [3:0] reg_wr_sel_in = 4'h0, reg_sel_in = 4'h0, lag = 4'h0;
	logic [2:0] mem_err_in, exc_code_out, err_sel = 3'h0, got_exc;
	logic [7:0] mem_rdata_in;
	logic [31:0] reg_wr_data_in = 32'h0, base_value_in = 32'h0, redirect_pc_out, v, got_pc;
	logic [31:0] return_register_out, global_base_out, reg_value_out;
	logic got_redir, got_done;
	ltx_instr_t instr_in = '0;
	ltx_mem_req_t mem_req_out;
	int fails = 0, n_checks = 0;
	ltx_exec i_dut (.*);
	ltx_mem_model i_mem (.clk_in(clk_in), .valid_in(mem_valid_out), .req_in(mem_req_out),
		.lag_in(lag), .err_sel_in(err_sel), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in),
		.err_out(mem_err_in));
	// free-running clock
	always #5 clk_in = ~clk_in;
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask
	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'h1) begin
			fails++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic setr(input logic [3:0] s, input logic [31:0] d);
		reg_wr_en_in = 1'h1;
		reg_wr_sel_in = s;
		reg_wr_data_in = d;
		tick;
		reg_wr_en_in = 1'h0;
	endtask
	// register view is registered, so allow it two cycles to settle
	task automatic rdreg(input logic [3:0] s);
		reg_sel_in = s;
		tick;
		tick;
		v = reg_value_out;
	endtask
	// offer one instruction, then wait for it to retire; bounded so a hang ends the run
	task automatic run(input logic [15:0] c, input logic [31:0] pc);
		int i;
		int j;
		instr_valid_in = 1'h1;
		instr_in = '{pc, c};
		for (i = 0; i < 40 && instr_ready_out !== 1'h1; i++) tick;
		tick;
		instr_valid_in = 1'h0;
		for (j = 0; j < 40 && done_out !== 1'h1 && exc_valid_out !== 1'h1; j++) tick;
		if (i == 40 || j == 40) begin
			fails++;
			$display("BAD %0t %s", $time, "instruction never retired");
			close_out;
		end
		got_done = done_out;
		got_redir = redirect_valid_out;
		got_pc = redirect_pc_out;
		got_exc = exc_valid_out ? exc_code_out : 3'h0;
	endtask
	task automatic sc_tests;
		setr(4'h1, 32'h000000F0);
		setr(4'h2, 32'h0000000F);
		run(16'h2128, 32'h0);
		chk(t_flag_out === 1'h1 && got_done === 1'h1, "and test zero");
		setr(4'h2, 32'h00000010);
		run(16'h2128, 32'h0);
		rdreg(4'h1);
		chk(t_flag_out === 1'h0 && v === 32'h000000F0, "and test nonzero");
		setr(4'h0, 32'hFFFFFF7F);
		run(16'hC880, 32'h0);
		chk(t_flag_out === 1'h1, "imm test zero");
		run(16'hC8FF, 32'h0);
		rdreg(4'h0);
		chk(t_flag_out === 1'h0 && v === 32'hFFFFFF7F, "imm test nonzero");
	endtask
	// flag is set first so a stray clear shows up
	task automatic sc_xor_extract;
		setr(4'h0, 32'h0);
		run(16'h2008, 32'h0);
		setr(4'h0, 32'hAAAAAAAA);
		setr(4'h1, 32'h55555555);
		// source is index zero, destination is register one
		run(16'h210A, 32'h0);
		rdreg(4'h1);
		chk(v === 32'hFFFFFFFF && t_flag_out === 1'h1, "reg xor");
		setr(4'h0, 32'hFFFFFFFF);
		run(16'hCAF0, 32'h0);
		rdreg(4'h0);
		chk(v === 32'hFFFFFF0F, "imm xor");
		setr(4'h0, 32'h01234567);
		setr(4'h1, 32'h89ABCDEF);
		run(16'h210D, 32'h0);
		rdreg(4'h1);
		chk(v === 32'h456789AB && t_flag_out === 1'h1, "extract");
	endtask
	task automatic sc_memory;
		int k;
		base_load_in = 1'h1;
		base_value_in = 32'h00000100;
		tick;
		base_load_in = 1'h0;
		setr(4'h0, 32'h00000005);
		i_mem.mem[9'h105] = 8'hA5;
		run(16'hCCA5, 32'h0);
		chk(t_flag_out === 1'h0 && i_mem.mem[9'h105] === 8'hA5, "mem test");
		lag = 4'h3;
		run(16'hCC5A, 32'h0);
		chk(t_flag_out === 1'h1 && global_base_out === 32'h00000100, "mem test zero");
		run(16'hCEA5, 32'h0);
		chk(got_done === 1'h1 && i_mem.mem[9'h105] === 8'h00, "mem xor");
		lag = 4'h0;
		for (k = 1; k < 6; k++) begin
			err_sel = k[2:0];
			run(16'hCEFF, 32'h0);
			chk(got_exc === k[2:0] && i_mem.mem[9'h105] === 8'h00, "mem fault");
		end
		err_sel = 3'h0;
	endtask
	// interrupt request held high throughout so any early acceptance is seen
	task automatic sc_branch;
		irq_req_in = 1'h1;
		run(16'hB800, 32'h00001000);
		chk(return_register_out === 32'h00001004 && irq_accept_out === 1'h0, "rel");
		run(16'h201A, 32'h00001002);
		chk(got_redir === 1'h1 && got_pc === 32'h00000004, "rel target");
		setr(4'h3, 32'h00000100);
		run(16'h0303, 32'h00002000);
		chk(return_register_out === 32'h00002004, "reg branch");
		run(16'hB000, 32'h00002002);
		chk(got_exc === 3'h6 && got_redir === 1'h0, "slot branch");
		run(16'h0303, 32'h00002000);
		run(16'h2008, 32'h00002002);
		chk(got_redir === 1'h1 && got_pc === 32'h00002104, "reg target");
		irq_req_in = 1'h0;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk_in);
		#1;
		reset_in = 1'h0;
		sc_tests;
		sc_xor_extract;
		sc_memory;
		sc_branch;
		close_out;
	end
endmodule
bind ltx_exec ltx_props i_props (.*);
`default_nettype wire

/* testbench/ltx_mem_model.sv */
// byte data memory answering the unit's access port after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module ltx_mem_model
	import ltx_pkg::*;
(
	input wire logic clk_in,
	input wire logic valid_in,
	input wire ltx_mem_req_t req_in,
	input wire logic [3:0] lag_in,
	input wire logic [2:0] err_sel_in,
	output logic ack_out = 1'h0,
	output logic [7:0] rdata_out = 8'h00,
	output logic [2:0] err_out = 3'h0
);
	logic [7:0] mem [512];
	logic [3:0] cnt = 4'h0;
	// one access at a time; read data turns over when idle so stale bytes never look valid
	always @(posedge clk_in) begin
		ack_out <= 1'h0;
		err_out <= 3'h0;
		rdata_out <= ~rdata_out;
		if (valid_in && !ack_out) begin
			if (cnt >= lag_in) begin
				ack_out <= 1'h1;
				cnt <= 4'h0;
				err_out <= err_sel_in; // faults only where the bench asks
				rdata_out <= mem[req_in.addr[8:0]];
				if (req_in.write && err_sel_in == 3'h0) begin
					mem[req_in.addr[8:0]] <= req_in.wdata;
				end
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/ltx_props.sv */
// port-level assertions for the test, exclusive-or, extract and branch unit
`timescale 1ns/1ps
`default_nettype none
`include "ltx_defines.svh"
module ltx_props
	import ltx_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic instr_valid_in,
	input wire ltx_instr_t instr_in,
	input wire logic instr_ready_out,
	input wire logic done_out,
	input wire logic redirect_valid_out,
	input wire logic [31:0] redirect_pc_out,
	input wire logic exc_valid_out,
	input wire logic [`LTX_EXC_W-1:0] exc_code_out,
	input wire logic irq_req_in,
	input wire logic irq_accept_out,
	input wire logic mem_valid_out,
	input wire ltx_mem_req_t mem_req_out,
	input wire logic mem_ack_in,
	input wire logic [7:0] mem_rdata_in,
	input wire logic [`LTX_EXC_W-1:0] mem_err_in,
	input wire logic reg_wr_en_in,
	input wire logic [3:0] reg_wr_sel_in,
	input wire logic [31:0] reg_wr_data_in,
	input wire logic base_load_in,
	input wire logic [31:0] base_value_in,
	input wire logic [3:0] reg_sel_in,
	input wire logic [31:0] reg_value_out,
	input wire logic t_flag_out,
	input wire logic [31:0] return_register_out,
	input wire logic [31:0] global_base_out
);
	logic owed, rel, xm;
	logic [7:0] imm;
	logic [31:0] tgt;
	wire logic take = instr_valid_in && instr_ready_out;
	function automatic logic sub_br(input logic [15:0] c);
		return c[15:12] == 4'hB || (c & 16'hF0FF) == 16'h0003;
	endfunction
	// remember what the last taken instruction owes; a slot take always settles it
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			owed <= 1'h0;
			rel <= 1'h0;
			xm <= 1'h0;
			imm <= 8'h00;
			tgt <= 32'h0;
		end else if (take) begin
			owed <= sub_br(instr_in.code) && !owed;
			rel <= instr_in.code[15:12] == 4'hB && !owed;
			xm <= instr_in.code[15:8] == 8'hCE;
			imm <= instr_in.code[7:0];
			if (instr_in.code[15:12] == 4'hB && !owed) begin
				tgt <= instr_in.pc + 32'h4 + {{19{instr_in.code[11]}}, instr_in.code[11:0], 1'h0};
			end
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_both; mem_valid_out |-> mem_req_out.check_both; endproperty
	a_both: assert property (p_both) else $error("byte access lacks dual check");
	property p_err; mem_valid_out && mem_ack_in && mem_err_in != 3'h0 |=> exc_valid_out && exc_code_out == $past(mem_err_in); endproperty
	a_err: assert property (p_err) else $error("memory fault not reported");
	property p_xwr; mem_valid_out && mem_ack_in && mem_err_in == 3'h0 && xm && !mem_req_out.write |=> mem_valid_out && mem_req_out.write && mem_req_out.wdata == ($past(mem_rdata_in) ^ imm); endproperty
	a_xwr: assert property (p_xwr) else $error("byte xor write wrong");
	property p_keep; take && instr_in.code[15:12] != 4'hC && instr_in.code[3:0] != 4'h8 |=> t_flag_out == $past(t_flag_out); endproperty
	a_keep: assert property (p_keep) else $error("flag moved");
	property p_ret; take && instr_in.code[15:12] == 4'hB && !owed |=> return_register_out == $past(instr_in.pc) + 32'h4; endproperty
	a_ret: assert property (p_ret) else $error("return address wrong");
	property p_irq; take && sub_br(instr_in.code) && !owed |=> !irq_accept_out; endproperty
	a_irq: assert property (p_irq) else $error("interrupt taken before slot");
	property p_ill; take && owed && sub_br(instr_in.code) |=> exc_valid_out && exc_code_out == 3'h6 && !redirect_valid_out; endproperty
	a_ill: assert property (p_ill) else $error("branch in slot not refused");
	property p_redir; take && owed && rel && instr_in.code[15:12] == 4'h2 |=> redirect_valid_out && redirect_pc_out == tgt; endproperty
	a_redir: assert property (p_redir) else $error("redirect wrong");
	c_slot: cover property (take && owed);
	c_exc: cover property (exc_valid_out);
	c_redir: cover property (redirect_valid_out);
endmodule
`default_nettype wire
